// ---- src/upc_regs.vh ----
`ifndef UPC_REGS_VH
`define UPC_REGS_VH

// register byte addresses
`define UPC_ADDR_SEL      8'h00
`define UPC_ADDR_CFG      8'h04
`define UPC_ADDR_BUF      8'h08
`define UPC_ADDR_CTL      8'h0C
`define UPC_ADDR_CUR      8'h10
`define UPC_ADDR_DATA     8'h14
`define UPC_ADDR_MAXP     8'h18
`define UPC_ADDR_TRN      8'h1C
`define UPC_ADDR_STAT     8'h20

// configuration, buffer and control register fields
`define UPC_CFG_TYPE_HI   15
`define UPC_CFG_TYPE_LO   14
`define UPC_CFG_ROR       10
`define UPC_CFG_DBL       9
`define UPC_CFG_CONT      8
`define UPC_CFG_DIR       4
`define UPC_BUF_SIZE_HI   14
`define UPC_BUF_SIZE_LO   10
`define UPC_CTL_PID_HI    1
`define UPC_CTL_PID_LO    0
`define UPC_CTL_CLR       8
`define UPC_CTL_VAL       9
`define UPC_CTL_ACLR      10

// transfer types and responses
`define UPC_TYPE_OFF      2'h0
`define UPC_TYPE_BULK     2'h1
`define UPC_TYPE_INTR     2'h2
`define UPC_TYPE_ISOC     2'h3
`define UPC_PID_NAK       2'h0
`define UPC_PID_BUF       2'h1

// pipe ranges
`define UPC_LAST_DUAL     4'h2
`define UPC_LAST_BULK     4'h5
`define UPC_LAST_PIPE     4'h9
`define UPC_NUM_PIPES     10

// reset values and bytes per data word
`define UPC_MAXP_RST      11'h040
`define UPC_TRN_RST       16'h0000
`define UPC_WORD_BYTES    13'h0004

`endif

// ---- src/upc_sync.v ----
`timescale 1ns/1ps
`default_nettype none

module upc_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input  wire             clk,
	input  wire             arst_n,
	// level in and out
	input  wire [WIDTH-1:0] d,
	output reg  [WIDTH-1:0] q
);

	reg [WIDTH-1:0] meta;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= {WIDTH{1'b0}};
			q    <= {WIDTH{1'b0}};
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule // upc_sync

`default_nettype wire

// ---- src/upc_fifo.v ----
`timescale 1ns/1ps
`default_nettype none

module upc_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// clock and reset
	input  wire             clk,
	input  wire             arst_n,
	input  wire             flush,
	// fill side
	input  wire             wr_valid,
	output wire             wr_ready,
	input  wire [WIDTH-1:0] wr_data,
	// drain side
	output wire             rd_valid,
	input  wire             rd_ready,
	output wire [WIDTH-1:0] rd_data,
	// fill level
	output wire [AW:0]      level
);

	localparam [AW:0] FULL_CNT = DEPTH;

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wptr;
	reg [AW-1:0]    rptr;
	reg [AW:0]      count;

	wire push = wr_valid & wr_ready;
	wire pop  = rd_valid & rd_ready;

	assign wr_ready = (count != FULL_CNT);
	assign rd_valid = (count != {(AW+1){1'b0}});
	assign rd_data  = mem[rptr];
	assign level    = count;

	// storage needs no reset; pointers and count define what is valid
	always @(posedge clk) begin
		if (push)
			mem[wptr] <= wr_data;
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wptr  <= {AW{1'b0}};
			rptr  <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else if (flush) begin
			wptr  <= {AW{1'b0}};
			rptr  <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wptr <= wptr + {{(AW-1){1'b0}}, 1'b1};
			if (pop)
				rptr <= rptr + {{(AW-1){1'b0}}, 1'b1};
			if (push & ~pop)
				count <= count + {{AW{1'b0}}, 1'b1};
			else if (pop & ~push)
				count <= count - {{AW{1'b0}}, 1'b1};
		end
	end

endmodule // upc_fifo

`default_nettype wire

// ---- src/upc_pipe_cfg.v ----
`timescale 1ns/1ps
`default_nettype none
`include "upc_regs.vh"

module upc_pipe_cfg #(
	parameter DATA_W     = 32,
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW    = 3
) (
	// clock and reset
	input  wire              clk,
	input  wire              arst_n,
	// apb slave
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [7:0]        paddr,
	input  wire [31:0]       pwdata,
	output reg  [31:0]       prdata,
	output reg               pready,
	output reg               pslverr,
	// control stage status from the control pipe logic
	input  wire              control_stage_status,
	// dma end strobe, asynchronous pin
	input  wire              dma_end_strobe,
	// usb receive stream
	input  wire              usb_rx_valid,
	output reg               usb_rx_ready,
	input  wire [DATA_W-1:0] usb_rx_data,
	input  wire              usb_rx_end,
	input  wire [10:0]       usb_rx_len,
	// usb transmit stream
	output reg               usb_tx_valid,
	input  wire              usb_tx_ready,
	output reg  [DATA_W-1:0] usb_tx_data,
	// buffer ready notice
	output reg               buffer_ready_irq,
	output reg  [3:0]        buffer_ready_pipe
);

	localparam [FIFO_AW:0] FIFO_FULL = FIFO_DEPTH;
	localparam [FIFO_AW:0] LVL_ONE   = 1;

	// per-pipe configuration
	reg  [1:0]  ptype [0:`UPC_NUM_PIPES-1];
	reg         ror   [0:`UPC_NUM_PIPES-1];
	reg         dbl   [0:`UPC_NUM_PIPES-1];
	reg         cont  [0:`UPC_NUM_PIPES-1];
	reg         dir   [0:`UPC_NUM_PIPES-1];
	reg  [4:0]  bsize [0:`UPC_NUM_PIPES-1];
	reg  [1:0]  pid   [0:`UPC_NUM_PIPES-1];

	reg  [3:0]  pipe_window_select;
	reg  [3:0]  current_fifo_pipe;
	reg  [10:0] maxp;
	reg  [15:0] trn_target;
	reg  [15:0] pkt_cnt;
	reg         fifo_auto_clear;
	reg         read_possible;
	reg         tx_possible;
	reg         rx_in_pkt;
	reg  [12:0] rx_bytes;
	reg  [12:0] tx_bytes;

	reg         next_rp;
	reg         next_tp;
	reg  [12:0] next_rx_bytes;
	reg  [12:0] next_tx_bytes;
	reg  [15:0] next_pkt;
	reg         irq_set;
	reg  [31:0] next_rdata;
	reg         next_err;

	wire              dma_end_sync;
	wire              fifo_wr_valid;
	wire              fifo_wr_ready;
	wire [DATA_W-1:0] fifo_wr_data;
	wire              fifo_rd_valid;
	wire              fifo_rd_ready;
	wire [DATA_W-1:0] fifo_rd_data;
	wire [FIFO_AW:0]  fifo_level;

	integer i;

	function type_legal;
		input [3:0] p;
		input [1:0] t;
		begin
			if (t == `UPC_TYPE_OFF)
				type_legal = 1'b1;
			else if (p <= `UPC_LAST_DUAL)
				type_legal = (t == `UPC_TYPE_BULK) | (t == `UPC_TYPE_ISOC);
			else if (p <= `UPC_LAST_BULK)
				type_legal = (t == `UPC_TYPE_BULK);
			else
				type_legal = (t == `UPC_TYPE_INTR);
		end
	endfunction

	wire [3:0] sp     = pipe_window_select;
	wire [3:0] cp     = current_fifo_pipe;
	wire       sel_ok = (sp != 4'h0);
	wire       cp_ok  = (cp != 4'h0);
	wire       sp_low = sel_ok & (sp <= `UPC_LAST_BULK);
	wire       cp_low = cp_ok & (cp <= `UPC_LAST_BULK);

	// effective modes; bits stored on pipes six-nine are kept but ignored
	wire ror_e  = ror[cp] & cp_low;
	wire dbl_e  = dbl[cp] & cp_low;
	wire cont_e = cont[cp] & cp_low & (ptype[cp] == `UPC_TYPE_BULK);

	// one buffer side and the window pipe's allocation
	wire [5:0]  side_blk   = {1'b0, bsize[cp]} + 6'h01;
	wire [12:0] side_bytes = {1'b0, side_blk, 6'h00};
	wire [5:0]  win_blk    = {1'b0, bsize[sp]} + 6'h01;
	wire [12:0] alloc      = (dbl[sp] & sp_low) ? {win_blk, 7'h00} : {1'b0, win_blk, 6'h00};

	// traffic only once a type is set and the response is BUF
	wire run     = cp_ok & (pid[cp] == `UPC_PID_BUF) & (ptype[cp] != `UPC_TYPE_OFF);
	wire cur_dir = dir[cp];
	wire pipe_busy_flag = rx_in_pkt | usb_tx_valid | (tx_possible & run);
	wire cfg_open = sel_ok & (pid[sp] == `UPC_PID_NAK) & ~control_stage_status & (sp != cp);

	// apb decode
	wire acc     = psel & penable & pready;
	wire wr_acc  = acc & pwrite;
	wire rd_acc  = acc & ~pwrite;
	wire is_sel  = (paddr == `UPC_ADDR_SEL);
	wire is_cfg  = (paddr == `UPC_ADDR_CFG);
	wire is_buf  = (paddr == `UPC_ADDR_BUF);
	wire is_ctl  = (paddr == `UPC_ADDR_CTL);
	wire is_cur  = (paddr == `UPC_ADDR_CUR);
	wire is_data = (paddr == `UPC_ADDR_DATA);
	wire is_maxp = (paddr == `UPC_ADDR_MAXP);
	wire is_trn  = (paddr == `UPC_ADDR_TRN);
	wire is_stat = (paddr == `UPC_ADDR_STAT);
	wire mapped  = is_sel | is_cfg | is_buf | is_ctl | is_cur | is_data | is_maxp | is_trn | is_stat;

	// a full fifo stalls the data write instead of dropping it
	wire tx_ok_push = cp_ok & cur_dir & ~tx_possible;
	wire stall      = psel & penable & pwrite & is_data & tx_ok_push & ~fifo_wr_ready;
	wire tx_push    = wr_acc & is_data & tx_ok_push;
	wire rx_push    = usb_rx_valid & usb_rx_ready;
	wire rx_pop     = rd_acc & is_data & ~cur_dir & fifo_rd_valid;
	// a full fifo streams out early since it is smaller than a buffer side
	wire tx_load    = cur_dir & run & fifo_rd_valid & (tx_possible | (fifo_level == FIFO_FULL))
			& (~usb_tx_valid | usb_tx_ready);
	wire win_cur    = wr_acc & is_ctl & (sp == cp) & cp_ok;
	wire clr_hit    = win_cur & pwdata[`UPC_CTL_CLR];
	wire buffer_valid_hit   = win_cur & pwdata[`UPC_CTL_VAL] & cur_dir;
	wire cur_change = wr_acc & is_cur & (pwdata[3:0] != cp) & (pwdata[3:0] <= `UPC_LAST_PIPE);
	wire flush      = fifo_auto_clear | clr_hit | cur_change;
	wire rx_end_hit = usb_rx_end & ~cur_dir & run & ~read_possible;

	wire [12:0] rx_tot  = rx_bytes + {2'b00, usb_rx_len};
	wire [12:0] tx_next = tx_bytes + `UPC_WORD_BYTES;
	wire [15:0] pkt_inc = pkt_cnt + 16'h0001;

	wire [FIFO_AW:0] lvl_next = fifo_level + {{FIFO_AW{1'b0}}, rx_push}
			- {{FIFO_AW{1'b0}}, fifo_rd_ready & fifo_rd_valid};

	assign fifo_wr_valid = cur_dir ? tx_push : rx_push;
	assign fifo_wr_data  = cur_dir ? pwdata[DATA_W-1:0] : usb_rx_data;
	assign fifo_rd_ready = cur_dir ? tx_load : rx_pop;

	upc_sync #(
		.WIDTH(1)
	) u_dma_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      (dma_end_strobe),
		.q      (dma_end_sync)
	);

	upc_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.clk      (clk),
		.arst_n   (arst_n),
		.flush    (flush),
		.wr_valid (fifo_wr_valid),
		.wr_ready (fifo_wr_ready),
		.wr_data  (fifo_wr_data),
		.rd_valid (fifo_rd_valid),
		.rd_ready (fifo_rd_ready),
		.rd_data  (fifo_rd_data),
		.level    (fifo_level)
	);

	// completion tracking for the pipe that owns the fifo
	always @* begin
		next_rp       = read_possible;
		next_tp       = tx_possible;
		next_rx_bytes = rx_bytes;
		next_tx_bytes = tx_bytes;
		next_pkt      = pkt_cnt;
		irq_set       = 1'b0;
		if (flush) begin
			next_rp       = 1'b0;
			next_tp       = 1'b0;
			next_rx_bytes = 13'h0000;
			next_tx_bytes = 13'h0000;
			next_pkt      = 16'h0000;
		end else begin
			if (rx_end_hit) begin
				next_pkt      = pkt_inc;
				next_rx_bytes = rx_tot;
				if (!cont_e)
					next_rp = 1'b1;
				else if ((rx_tot >= side_bytes)
						|| ((usb_rx_len != 11'h000) && (usb_rx_len < maxp))
						|| ((usb_rx_len == 11'h000) && (rx_bytes != 13'h0000))
						|| ((trn_target != 16'h0000) && (pkt_inc == trn_target)))
					next_rp = 1'b1;
				if (next_rp) begin
					next_rx_bytes = 13'h0000;
					if ((trn_target != 16'h0000) && (pkt_inc == trn_target))
						next_pkt = 16'h0000;
					if (!ror_e)
						irq_set = 1'b1;
				end
			end
			if (read_possible && ror_e && rx_pop && (fifo_level == LVL_ONE))
				irq_set = 1'b1;
			if (read_possible && !ror_e && (fifo_level == {(FIFO_AW+1){1'b0}}))
				next_rp = 1'b0;
			if (tx_push) begin
				next_tx_bytes = tx_next;
				if (!cont_e && (tx_next >= {2'b00, maxp}))
					next_tp = 1'b1;
				if (cont_e && (tx_next >= side_bytes))
					next_tp = 1'b1;
				if (cont_e && dma_end_sync)
					next_tp = 1'b1;
			end
			if (buffer_valid_hit)
				next_tp = 1'b1;
			if (tx_possible && run && !usb_tx_valid && (fifo_level == {(FIFO_AW+1){1'b0}})) begin
				next_tp       = 1'b0;
				next_tx_bytes = 13'h0000;
				if (!(ror_e | dbl_e))
					irq_set = 1'b1;
			end
		end
	end

	// read mux; the data port reads zero when nothing is stored
	always @* begin
		next_rdata = 32'h0000_0000;
		next_err   = ~mapped;
		if (is_sel)
			next_rdata = {28'h000_0000, sp};
		else if (is_cfg && sel_ok)
			next_rdata = {16'h0000, ptype[sp], 3'h0, ror[sp], dbl[sp], cont[sp], 3'h0,
					dir[sp], 4'h0};
		else if (is_buf && sel_ok)
			next_rdata = {17'h0_0000, bsize[sp], 10'h000};
		else if (is_ctl)
			next_rdata = {21'h00_0000, fifo_auto_clear, 8'h00, sel_ok ? pid[sp] : 2'h0};
		else if (is_cur)
			next_rdata = {28'h000_0000, cp};
		else if (is_data && fifo_rd_valid && !cur_dir)
			next_rdata = fifo_rd_data;
		else if (is_maxp)
			next_rdata = {21'h00_0000, maxp};
		else if (is_trn)
			next_rdata = {16'h0000, trn_target};
		else if (is_stat)
			next_rdata = {3'h0, alloc, 12'h000, pipe_busy_flag, control_stage_status,
					tx_possible, read_possible};
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (i = 0; i < `UPC_NUM_PIPES; i = i + 1) begin
				ptype[i] <= `UPC_TYPE_OFF;
				ror[i]   <= 1'b0;
				dbl[i]   <= 1'b0;
				cont[i]  <= 1'b0;
				dir[i]   <= 1'b0;
				bsize[i] <= 5'h00;
				pid[i]   <= `UPC_PID_NAK;
			end
			pipe_window_select <= 4'h0;
			current_fifo_pipe  <= 4'h0;
			maxp               <= `UPC_MAXP_RST;
			trn_target         <= `UPC_TRN_RST;
			fifo_auto_clear    <= 1'b0;
			pready             <= 1'b0;
			pslverr            <= 1'b0;
			prdata             <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready & ~stall;
			pslverr <= psel & penable & ~pready & ~stall & next_err;
			prdata  <= (psel & penable & ~pready & ~pwrite) ? next_rdata : 32'h0000_0000;
			if (wr_acc && is_sel && (pwdata[3:0] <= `UPC_LAST_PIPE))
				pipe_window_select <= pwdata[3:0];
			if (cur_change)
				current_fifo_pipe <= pwdata[3:0];
			if (wr_acc && is_maxp)
				maxp <= pwdata[10:0];
			if (wr_acc && is_trn)
				trn_target <= pwdata[15:0];
			if (wr_acc && is_cfg && sel_ok) begin
				if ((pid[sp] == `UPC_PID_NAK)
						&& type_legal(sp, pwdata[`UPC_CFG_TYPE_HI:`UPC_CFG_TYPE_LO]))
					ptype[sp] <= pwdata[`UPC_CFG_TYPE_HI:`UPC_CFG_TYPE_LO];
				if (cfg_open) begin
					ror[sp]  <= pwdata[`UPC_CFG_ROR];
					dbl[sp]  <= pwdata[`UPC_CFG_DBL];
					cont[sp] <= pwdata[`UPC_CFG_CONT];
					dir[sp]  <= pwdata[`UPC_CFG_DIR];
				end
			end
			if (wr_acc && is_buf && cfg_open)
				bsize[sp] <= pwdata[`UPC_BUF_SIZE_HI:`UPC_BUF_SIZE_LO];
			if (wr_acc && is_ctl) begin
				fifo_auto_clear <= pwdata[`UPC_CTL_ACLR];
				if (sel_ok && (pwdata[`UPC_CTL_PID_HI:`UPC_CTL_PID_LO] <= `UPC_PID_BUF))
					pid[sp] <= pwdata[`UPC_CTL_PID_HI:`UPC_CTL_PID_LO];
			end
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			read_possible     <= 1'b0;
			tx_possible       <= 1'b0;
			rx_bytes          <= 13'h0000;
			tx_bytes          <= 13'h0000;
			pkt_cnt           <= 16'h0000;
			rx_in_pkt         <= 1'b0;
			usb_rx_ready      <= 1'b0;
			usb_tx_valid      <= 1'b0;
			usb_tx_data       <= {DATA_W{1'b0}};
			buffer_ready_irq  <= 1'b0;
			buffer_ready_pipe <= 4'h0;
		end else begin
			read_possible     <= next_rp;
			tx_possible       <= next_tp;
			rx_bytes          <= next_rx_bytes;
			tx_bytes          <= next_tx_bytes;
			pkt_cnt           <= next_pkt;
			buffer_ready_irq  <= irq_set;
			buffer_ready_pipe <= irq_set ? cp : 4'h0;
			// ready is registered, so it looks one word ahead
			usb_rx_ready <= ~cur_dir & run & ~next_rp & ~flush & ~cur_change
					& (lvl_next < FIFO_FULL);
			if (flush)
				rx_in_pkt <= 1'b0;
			else if (usb_rx_end)
				rx_in_pkt <= 1'b0;
			else if (rx_push)
				rx_in_pkt <= 1'b1;
			if (flush) begin
				usb_tx_valid <= 1'b0;
			end else if (tx_load) begin
				usb_tx_valid <= 1'b1;
				usb_tx_data  <= fifo_rd_data;
			end else if (usb_tx_ready) begin
				usb_tx_valid <= 1'b0;
			end
		end
	end

endmodule // upc_pipe_cfg

`default_nettype wire

// ---- verification/upc_pipe_cfg_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "upc_regs.vh"

module upc_pipe_cfg_asserts #(
	parameter DATA_W = 32
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              arst_n,
	// apb
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       prdata,
	input  wire logic              pready,
	input  wire logic              pslverr,
	// transmit stream and notice
	input  wire logic              usb_tx_valid,
	input  wire logic              usb_tx_ready,
	input  wire logic [DATA_W-1:0] usb_tx_data,
	input  wire logic              buffer_ready_irq,
	input  wire logic [3:0]        buffer_ready_pipe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	// data port writes may stall on a full buffer, so they are left out here
	chk_one_wait: assert property (psel && $rose(penable) && !(pwrite && paddr == `UPC_ADDR_DATA)
		|=> pready) else $error("access not answered after one wait state");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than a cycle");
	chk_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
	chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside completion");
	chk_tx_hold: assert property (usb_tx_valid && !usb_tx_ready |=>
		usb_tx_valid && $stable(usb_tx_data)) else $error("transmit word not held");
	chk_irq_pulse: assert property (buffer_ready_irq |=> !buffer_ready_irq)
		else $error("notice longer than a cycle");
	chk_irq_pipe: assert property (buffer_ready_irq |-> buffer_ready_pipe inside {[4'h1:4'h9]})
		else $error("notice names no data pipe");
	chk_irq_idle: assert property (!buffer_ready_irq |-> buffer_ready_pipe == 4'h0)
		else $error("pipe number without notice");
endmodule // upc_pipe_cfg_asserts

bind upc_pipe_cfg upc_pipe_cfg_asserts #(.DATA_W(DATA_W)) u_upc_pipe_cfg_asserts (
	.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.usb_tx_valid(usb_tx_valid), .usb_tx_ready(usb_tx_ready), .usb_tx_data(usb_tx_data),
	.buffer_ready_irq(buffer_ready_irq), .buffer_ready_pipe(buffer_ready_pipe));
`default_nettype wire

// ---- verification/upc_usb_peer.sv ----
`timescale 1ns/1ps
`default_nettype none

module upc_usb_peer #(
	parameter DATA_W = 32
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              arst_n,
	// holds transmit ready low while set
	input  wire logic              stall,
	// receive stream toward the block
	output var  logic              usb_rx_valid,
	input  wire logic              usb_rx_ready,
	output var  logic [DATA_W-1:0] usb_rx_data,
	output var  logic              usb_rx_end,
	output var  logic [10:0]       usb_rx_len,
	// transmit stream from the block
	input  wire logic              usb_tx_valid,
	output var  logic              usb_tx_ready,
	input  wire logic [DATA_W-1:0] usb_tx_data
);
	logic [DATA_W-1:0] got [$];

	initial begin
		usb_rx_valid = 1'b0;
		usb_rx_data = '0;
		usb_rx_end = 1'b0;
		usb_rx_len = 11'h000;
	end

	// one packet of n words, end pulse right after the last accepted word
	task automatic send(input int n, input logic [DATA_W-1:0] base);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			usb_rx_valid <= 1'b1;
			usb_rx_data <= base + i;
			do @(posedge clk); while (usb_rx_ready !== 1'b1);
			usb_rx_valid <= 1'b0;
			// released data toggles so a stale word never looks valid
			usb_rx_data <= ~(base + i);
		end
		usb_rx_end <= 1'b1;
		usb_rx_len <= 11'(n * 4);
		@(posedge clk);
		usb_rx_end <= 1'b0;
		usb_rx_len <= 11'h000;
	endtask

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			usb_tx_ready <= 1'b0;
		else
			usb_tx_ready <= !stall;
	end

	always @(posedge clk) begin
		if (arst_n && usb_tx_valid && usb_tx_ready)
			got.push_back(usb_tx_data);
	end
endmodule // upc_usb_peer
`default_nettype wire

// ---- verification/test_usb_pipe_config_fifo_policy.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "upc_regs.vh"
`define UPC_CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected at %0t got %h exp %h", $time, g, e); end end

module test_usb_pipe_config_fifo_policy;
	typedef struct packed {
		logic [3:0]  s;
		logic [7:0]  wa;
		logic [31:0] wd;
		logic [7:0]  ra;
		logic [31:0] ex;
	} upc_row_t;
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr, control_stage_status;
	logic dma_end_strobe, stall, usb_rx_valid, usb_rx_ready, usb_rx_end;
	logic usb_tx_valid, usb_tx_ready, buffer_ready_irq, rerr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, usb_rx_data, usb_tx_data, rdat;
	logic [10:0] usb_rx_len;
	logic [3:0] buffer_ready_pipe, irq_pipe;
	int error_cnt, cmp_count, cyc, irq_n, w_cnt;
	upc_row_t rows [11];

	upc_pipe_cfg #(.DATA_W(32), .FIFO_DEPTH(8), .FIFO_AW(3)) u_upc_pipe_cfg (
		.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.control_stage_status(control_stage_status), .dma_end_strobe(dma_end_strobe),
		.usb_rx_valid(usb_rx_valid), .usb_rx_ready(usb_rx_ready), .usb_rx_data(usb_rx_data),
		.usb_rx_end(usb_rx_end), .usb_rx_len(usb_rx_len), .usb_tx_valid(usb_tx_valid),
		.usb_tx_ready(usb_tx_ready), .usb_tx_data(usb_tx_data),
		.buffer_ready_irq(buffer_ready_irq), .buffer_ready_pipe(buffer_ready_pipe));

	upc_usb_peer #(.DATA_W(32)) u_upc_usb_peer (
		.clk(clk), .arst_n(arst_n), .stall(stall), .usb_rx_valid(usb_rx_valid),
		.usb_rx_ready(usb_rx_ready), .usb_rx_data(usb_rx_data), .usb_rx_end(usb_rx_end),
		.usb_rx_len(usb_rx_len), .usb_tx_valid(usb_tx_valid), .usb_tx_ready(usb_tx_ready),
		.usb_tx_data(usb_tx_data));

	task automatic stop_test;
		if (error_cnt == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// flush and idle check before any mode change, then start traffic
	task automatic pipe_on(input logic [3:0] p, input logic [31:0] cfg);
		apb(1'b1, `UPC_ADDR_SEL, {28'h000_0000, p});
		apb(1'b1, `UPC_ADDR_CTL, 32'h0000_0400);
		apb(1'b1, `UPC_ADDR_CTL, 32'h0000_0000);
		apb(1'b0, `UPC_ADDR_STAT, 32'h0000_0000);
		`UPC_CHK(rdat[3:2], 2'b00)
		apb(1'b1, `UPC_ADDR_CFG, cfg);
		apb(1'b1, `UPC_ADDR_CUR, {28'h000_0000, p});
		apb(1'b1, `UPC_ADDR_CTL, 32'h0000_0001);
		u_upc_usb_peer.got.delete();
		irq_n = 0;
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (buffer_ready_irq === 1'b1) begin
			irq_n++;
			irq_pipe <= buffer_ready_pipe;
		end
		// whole run needs well under this many cycles
		if (cyc == 20000) begin
			error_cnt++;
			stop_test();
		end
	end

	initial begin
		{arst_n, psel, penable, pwrite, control_stage_status, dma_end_strobe, stall} = '0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		rows = '{'{4'h1, `UPC_ADDR_CFG, 32'h0000_C000, `UPC_ADDR_CFG, 32'h0000_C000},
			'{4'h1, `UPC_ADDR_CFG, 32'h0000_8000, `UPC_ADDR_CFG, 32'h0000_C000},
			'{4'h3, `UPC_ADDR_CFG, 32'h0000_C000, `UPC_ADDR_CFG, 32'h0000_0000},
			'{4'h3, `UPC_ADDR_CFG, 32'h0000_4000, `UPC_ADDR_CFG, 32'h0000_4000},
			'{4'h6, `UPC_ADDR_CFG, 32'h0000_4000, `UPC_ADDR_CFG, 32'h0000_0000},
			'{4'h9, `UPC_ADDR_CFG, 32'h0000_8000, `UPC_ADDR_CFG, 32'h0000_8000},
			'{4'h1, `UPC_ADDR_BUF, 32'h0000_0C00, `UPC_ADDR_STAT, 32'h0100_0000},
			'{4'h1, `UPC_ADDR_CFG, 32'h0000_4200, `UPC_ADDR_STAT, 32'h0200_0000},
			'{4'h6, `UPC_ADDR_BUF, 32'h0000_0400, `UPC_ADDR_STAT, 32'h0080_0000},
			'{4'h6, `UPC_ADDR_CFG, 32'h0000_8200, `UPC_ADDR_STAT, 32'h0080_0000},
			'{4'h0, `UPC_ADDR_CFG, 32'h0000_4000, `UPC_ADDR_CFG, 32'h0000_0000}};
		repeat (12) @(posedge clk);
		`UPC_CHK({pready, usb_rx_ready, usb_tx_valid, buffer_ready_irq}, 4'h0)
		arst_n <= 1'b1;
		apb(1'b0, 8'h24, 32'h0000_0000);
		`UPC_CHK({rerr, rdat}, 33'h1_0000_0000)
		foreach (rows[i]) begin
			apb(1'b1, `UPC_ADDR_SEL, {28'h000_0000, rows[i].s});
			apb(1'b1, rows[i].wa, rows[i].wd);
			apb(1'b0, rows[i].ra, 32'h0000_0000);
			`UPC_CHK(rdat, rows[i].ex)
		end
		// type frozen while running, modes frozen while current or stage busy
		apb(1'b1, `UPC_ADDR_SEL, 32'h0000_0004);
		apb(1'b1, `UPC_ADDR_CFG, 32'h0000_4000);
		apb(1'b1, `UPC_ADDR_CTL, 32'h0000_0001);
		apb(1'b1, `UPC_ADDR_CFG, 32'h0000_0000);
		apb(1'b0, `UPC_ADDR_CFG, 32'h0000_0000);
		`UPC_CHK(rdat, 32'h0000_4000)
		apb(1'b1, `UPC_ADDR_CTL, 32'h0000_0000);
		apb(1'b1, `UPC_ADDR_CUR, 32'h0000_0004);
		apb(1'b1, `UPC_ADDR_CFG, 32'h0000_4100);
		apb(1'b0, `UPC_ADDR_CFG, 32'h0000_0000);
		`UPC_CHK(rdat, 32'h0000_4000)
		apb(1'b1, `UPC_ADDR_CUR, 32'h0000_0000);
		control_stage_status <= 1'b1;
		apb(1'b1, `UPC_ADDR_CFG, 32'h0000_4100);
		apb(1'b0, `UPC_ADDR_CFG, 32'h0000_0000);
		`UPC_CHK(rdat, 32'h0000_4000)
		control_stage_status <= 1'b0;
		apb(1'b1, `UPC_ADDR_CFG, 32'h0000_4100);
		apb(1'b0, `UPC_ADDR_CFG, 32'h0000_0000);
		`UPC_CHK(rdat, 32'h0000_4100)
		// plain receive: notice per packet
		pipe_on(4'h1, 32'h0000_4000);
		u_upc_usb_peer.send(3, 32'hA000_0000);
		repeat (4) @(posedge clk);
		`UPC_CHK({irq_n[3:0], irq_pipe}, 8'h11)
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, `UPC_ADDR_DATA, 32'h0000_0000);
			`UPC_CHK(rdat, 32'hA000_0000 + i)
		end
		apb(1'b0, `UPC_ADDR_STAT, 32'h0000_0000);
		`UPC_CHK(rdat[0], 1'b0)
		// ready-on-read receive: notice only after readout, buffer kept until clear
		pipe_on(4'h2, 32'h0000_4400);
		u_upc_usb_peer.send(2, 32'hB000_0000);
		repeat (10) @(posedge clk);
		`UPC_CHK(irq_n[3:0], 4'h0)
		for (int i = 0; i < 2; i++) begin
			apb(1'b0, `UPC_ADDR_DATA, 32'h0000_0000);
			`UPC_CHK(rdat, 32'hB000_0000 + i)
		end
		repeat (4) @(posedge clk);
		`UPC_CHK({irq_n[3:0], irq_pipe}, 8'h12)
		apb(1'b0, `UPC_ADDR_STAT, 32'h0000_0000);
		`UPC_CHK(rdat[0], 1'b1)
		apb(1'b1, `UPC_ADDR_CTL, 32'h0000_0101);
		apb(1'b0, `UPC_ADDR_STAT, 32'h0000_0000);
		`UPC_CHK(rdat[0], 1'b0)
		// transmit one max packet while the peer stalls: buffer fills and refuses
		pipe_on(4'h3, 32'h0000_4010);
		stall <= 1'b1;
		w_cnt = 0;
		fork
			begin
				repeat (300) @(posedge clk);
				`UPC_CHK(w_cnt, 9)
				stall <= 1'b0;
			end
			for (int i = 0; i < 16; i++) begin
				apb(1'b1, `UPC_ADDR_DATA, 32'hC000_0000 + i);
				w_cnt++;
			end
		join
		while (u_upc_usb_peer.got.size() < 16) @(posedge clk);
		repeat (4) @(posedge clk);
		for (int i = 0; i < 16; i++)
			`UPC_CHK(u_upc_usb_peer.got[i], 32'hC000_0000 + i)
		`UPC_CHK({irq_n[3:0], irq_pipe}, 8'h13)
		// continuous transmit: end strobe, then buffer valid; no notice with ready-on-read
		pipe_on(4'h5, 32'h0000_4510);
		dma_end_strobe <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b1, `UPC_ADDR_DATA, 32'hD000_0000);
		dma_end_strobe <= 1'b0;
		while (u_upc_usb_peer.got.size() < 1) @(posedge clk);
		apb(1'b1, `UPC_ADDR_DATA, 32'hD000_0001);
		apb(1'b1, `UPC_ADDR_CTL, 32'h0000_0201);
		while (u_upc_usb_peer.got.size() < 2) @(posedge clk);
		repeat (4) @(posedge clk);
		`UPC_CHK(u_upc_usb_peer.got[0], 32'hD000_0000)
		`UPC_CHK(u_upc_usb_peer.got[1], 32'hD000_0001)
		`UPC_CHK(irq_n[3:0], 4'h0)
		stop_test();
	end
endmodule // test_usb_pipe_config_fifo_policy
`default_nettype wire
